// ---- pkg/sls_pkg.sv ----
// Purpose: Shared constants and types for the signal limit supervisor
// Assumes: Signal and limit values in hundredths, signed 32-bit
// Notes:   Filter time in milliseconds (1000 counts = 1 s)
`default_nettype none
package sls_pkg;
	// ----------------------------------------------------------------
	// Comparison modes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF     = 4'h0;
	localparam logic [3:0] MODE_LOW     = 4'h1;
	localparam logic [3:0] MODE_HIGH    = 4'h2;
	localparam logic [3:0] MODE_ABS_LO  = 4'h3;
	localparam logic [3:0] MODE_ABS_HI  = 4'h4;
	localparam logic [3:0] MODE_BOTH    = 4'h5;
	localparam logic [3:0] MODE_ABS_BO  = 4'h6;
	localparam logic [3:0] MODE_HYST    = 4'h7;
	localparam logic [3:0] MODE_LO_FALL = 4'h8;
	localparam logic [3:0] MODE_HI_RISE = 4'h9;
	// ----------------------------------------------------------------
	// Actions and event codes
	// ----------------------------------------------------------------
	localparam logic [1:0]  ACT_NONE      = 2'h0;
	localparam logic [1:0]  ACT_WARN      = 2'h1;
	localparam logic [1:0]  ACT_FAULT     = 2'h2;
	localparam logic [1:0]  ACT_FAULT_RUN = 2'h3;
	localparam logic [15:0] CODE_WARN     = 16'hA8B2;
	localparam logic [15:0] CODE_FAULT    = 16'h80B2;
	localparam logic [15:0] CODE_FLT_RUN  = 16'h80B0;
	localparam logic [15:0] CODE_NONE     = 16'h0000;
	// ----------------------------------------------------------------
	// Ranges and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]         SEL_TORQUE  = 4'h0;
	localparam logic [15:0]        FILT_MAX_MS = 16'h7530;
	localparam logic signed [31:0] LIMIT_MAX   = 32'sh7FFF_FFD0;
	localparam logic [31:0]        HYST_MAX    = 32'h0098_9680;
	localparam int unsigned        TICK_MS_DEF = 1;
	// Edge tracker for the falling and rising modes
	typedef enum logic [2:0] {
		EDGE_WAIT  = 3'b001,
		EDGE_ARMED = 3'b010,
		EDGE_HIT   = 3'b100
	} sls_edge_t;
	typedef struct packed {
		logic [3:0]         mode;
		logic [1:0]         action;
		logic [3:0]         sel;
		logic [15:0]        filt_ms;
		logic signed [31:0] low;
		logic signed [31:0] high;
		logic [31:0]        hyst;
	} sls_cfg_t;
	typedef struct packed {
		logic        status;
		logic        warn;
		logic        trip;
		logic [15:0] warn_code;
		logic [15:0] trip_code;
	} sls_evt_t;
	typedef struct packed {
		sls_cfg_t           cfg;
		logic signed [31:0] filt;
		logic               cond;
		sls_edge_t          edge_st;
		sls_evt_t           evt;
	} sls_state_t;
	localparam sls_cfg_t CFG_RST = '{mode: MODE_OFF, action: ACT_NONE, sel: SEL_TORQUE,
		filt_ms: 16'h0000, low: 32'sh0, high: 32'sh0, hyst: 32'h0};
endpackage
`default_nettype wire

// ---- src/sls_supervisor.sv ----
// Purpose: One signal limit supervision instance of a motor drive
// Assumes: tick marks one supervision cycle; inputs synchronous to clk
// Notes:   Configuration is loaded by cfg_wr and clamped to legal ranges
`timescale 1ns/1ps
`default_nettype none

module sls_supervisor
	import sls_pkg::*;
#(
	parameter int unsigned NSIG    = 8,
	parameter int unsigned TICK_MS = TICK_MS_DEF
) (
	// Clock, reset, enable
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      clk_en,
	// Supervision cycle strobe
	input  wire logic                      tick,
	// Configuration load
	input  wire logic                      cfg_wr,
	input  wire sls_cfg_t                  cfg_in,
	// Monitored signals and drive state
	input  wire logic signed [NSIG-1:0][31:0] sig_vec,
	input  wire logic                      motor_run,
	// Results
	output var  sls_cfg_t                  cfg_out,
	output var  logic signed [31:0]        filt_out,
	output var  sls_evt_t                  evt_out
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Sign extension to the comparison width
	function automatic logic signed [33:0] sx34(input logic signed [31:0] v);
		return {{2{v[31]}}, v};
	endfunction

	// Magnitude; 34 bits so the most negative limit cannot wrap
	function automatic logic [33:0] mag34(input logic signed [33:0] v);
		return v[33] ? 34'(-v) : 34'(v);
	endfunction

	// Saturate a limit to the legal span
	function automatic logic signed [31:0] clamp_lim(input logic signed [31:0] v);
		if (v > LIMIT_MAX) begin
			return LIMIT_MAX;
		end
		if (v < -LIMIT_MAX) begin
			return -LIMIT_MAX;
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// State and working signals
	// ----------------------------------------------------------------
	sls_state_t         st_q;
	sls_state_t         st_d;
	logic signed [31:0] sig_sel;
	logic signed [31:0] filt_n;
	logic signed [32:0] diff;
	logic signed [32:0] step;
	logic [16:0]        div_k;
	logic signed [33:0] x_s;
	logic signed [33:0] half_h;
	logic signed [33:0] lo_m;
	logic signed [33:0] lo_p;
	logic signed [33:0] hi_m;
	logic signed [33:0] hi_p;
	logic               below_lo;
	logic               above_lo;
	logic               below_hi;
	logic               above_hi;
	logic               abs_below_lo;
	logic               abs_above_lo;
	logic               abs_below_hi;
	logic               abs_above_hi;
	logic               cond_n;
	logic               mode_chg;
	sls_edge_t          edge_n;

	// ----------------------------------------------------------------
	// Signal selection
	// ----------------------------------------------------------------
	// Codes past the last input read as zero, a harmless idle choice
	always_comb begin
		sig_sel = 32'sh0;
		if (32'(st_q.cfg.sel) < NSIG) begin
			sig_sel = sig_vec[st_q.cfg.sel];
		end
	end

	// ----------------------------------------------------------------
	// Filter step
	// ----------------------------------------------------------------
	// Divisor is time over tick plus one, so zero time gives one full step.
	// A divider costs area but avoids a per-setting coefficient table.
	always_comb begin
		div_k = 17'(32'(st_q.cfg.filt_ms) / TICK_MS) + 17'h00001;
		diff  = {sig_sel[31], sig_sel} - {st_q.filt[31], st_q.filt};
		step  = 33'(diff / $signed({1'b0, div_k}));
		filt_n = tick ? st_q.filt + 32'(step) : st_q.filt;
	end

	// ----------------------------------------------------------------
	// Thresholds and comparisons on the freshly filtered value
	// ----------------------------------------------------------------
	always_comb begin
		x_s    = sx34(filt_n);
		half_h = $signed({2'h0, st_q.cfg.hyst >> 1});
		lo_m   = sx34(st_q.cfg.low) - half_h;
		lo_p   = sx34(st_q.cfg.low) + half_h;
		hi_m   = sx34(st_q.cfg.high) - half_h;
		hi_p   = sx34(st_q.cfg.high) + half_h;
		below_lo     = x_s < lo_m;
		above_lo     = x_s > lo_p;
		below_hi     = x_s < hi_m;
		above_hi     = x_s > hi_p;
		abs_below_lo = mag34(x_s) < mag34(lo_m);
		abs_above_lo = mag34(x_s) > mag34(lo_p);
		abs_below_hi = mag34(x_s) < mag34(hi_m);
		abs_above_hi = mag34(x_s) > mag34(hi_p);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d     = st_q;
		cond_n   = st_q.cond;
		edge_n   = st_q.edge_st;
		mode_chg = 1'b0;
		// Configuration load with range clamping
		if (cfg_wr) begin
			st_d.cfg      = cfg_in;
			st_d.cfg.low  = clamp_lim(cfg_in.low);
			st_d.cfg.high = clamp_lim(cfg_in.high);
			if (cfg_in.filt_ms > FILT_MAX_MS) begin
				st_d.cfg.filt_ms = FILT_MAX_MS;
			end
			if (cfg_in.hyst > HYST_MAX) begin
				st_d.cfg.hyst = HYST_MAX;
			end
			mode_chg = cfg_in.mode != st_q.cfg.mode;
		end
		// Filter advances once per supervision cycle
		st_d.filt = filt_n;
		// Comparison, evaluated once per supervision cycle
		if (tick) begin
			unique case (st_q.cfg.mode)
				MODE_LOW: begin
					if (below_lo) cond_n = 1'b1;
					else if (above_lo) cond_n = 1'b0;
				end
				MODE_HIGH: begin
					if (above_hi) cond_n = 1'b1;
					else if (below_hi) cond_n = 1'b0;
				end
				MODE_ABS_LO: begin
					if (abs_below_lo) cond_n = 1'b1;
					else if (abs_above_lo) cond_n = 1'b0;
				end
				MODE_ABS_HI: begin
					if (abs_above_hi) cond_n = 1'b1;
					else if (abs_below_hi) cond_n = 1'b0;
				end
				MODE_BOTH: begin
					if (above_hi || below_lo) cond_n = 1'b1;
					else if (below_hi && above_lo) cond_n = 1'b0;
				end
				MODE_ABS_BO: begin
					if (abs_above_hi || abs_below_lo) cond_n = 1'b1;
					else if (abs_below_hi && abs_above_lo) cond_n = 1'b0;
				end
				MODE_HYST: begin
					if (above_hi) cond_n = 1'b1;
					else if (below_lo) cond_n = 1'b0;
				end
				MODE_LO_FALL: begin
					unique case (st_q.edge_st)
						EDGE_WAIT: if (above_lo) edge_n = EDGE_ARMED;
						EDGE_ARMED: if (below_lo) edge_n = EDGE_HIT;
						EDGE_HIT: if (above_lo) edge_n = EDGE_ARMED;
						default: edge_n = EDGE_WAIT;
					endcase
					cond_n = edge_n == EDGE_HIT;
				end
				MODE_HI_RISE: begin
					unique case (st_q.edge_st)
						EDGE_WAIT: if (below_hi) edge_n = EDGE_ARMED;
						EDGE_ARMED: if (above_hi) edge_n = EDGE_HIT;
						EDGE_HIT: if (below_hi) edge_n = EDGE_ARMED;
						default: edge_n = EDGE_WAIT;
					endcase
					cond_n = edge_n == EDGE_HIT;
				end
				default: begin
					cond_n = 1'b0;
					edge_n = EDGE_WAIT;
				end
			endcase
		end
		// Disabled mode or a mode switch restarts detection from idle
		if (st_q.cfg.mode == MODE_OFF || st_q.cfg.mode > MODE_HI_RISE || mode_chg) begin
			cond_n = 1'b0;
			edge_n = EDGE_WAIT;
		end
		st_d.cond    = cond_n;
		st_d.edge_st = edge_n;
		// Status ignores the action setting
		st_d.evt.status    = cond_n;
		st_d.evt.warn      = 1'b0;
		st_d.evt.trip      = 1'b0;
		st_d.evt.warn_code = CODE_NONE;
		st_d.evt.trip_code = CODE_NONE;
		unique case (st_q.cfg.action)
			ACT_NONE: begin
				st_d.evt.warn = 1'b0;
			end
			ACT_WARN: begin
				st_d.evt.warn      = cond_n;
				st_d.evt.warn_code = cond_n ? CODE_WARN : CODE_NONE;
			end
			ACT_FAULT: begin
				st_d.evt.trip      = cond_n;
				st_d.evt.trip_code = cond_n ? CODE_FAULT : CODE_NONE;
			end
			ACT_FAULT_RUN: begin
				st_d.evt.trip      = cond_n && motor_run;
				st_d.evt.trip_code = (cond_n && motor_run) ? CODE_FLT_RUN : CODE_NONE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Enable low freezes everything, including the filter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{cfg: CFG_RST, filt: 32'sh0, cond: 1'b0, edge_st: EDGE_WAIT, evt: '0};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign cfg_out  = st_q.cfg;
	assign filt_out = st_q.filt;
	assign evt_out  = st_q.evt;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_step_on;
		clk_en && tick && !cfg_wr;
	endsequence

	sequence s_lo_armed_drop;
		s_step_on ##0 st_q.cfg.mode == MODE_LO_FALL && st_q.edge_st == EDGE_ARMED && below_lo;
	endsequence

	sequence s_lo_idle_drop;
		s_step_on ##0 st_q.cfg.mode == MODE_LO_FALL && st_q.edge_st == EDGE_WAIT && !above_lo;
	endsequence

	mode_off_quiet_a: assert property (
		clk_en && st_q.cfg.mode == MODE_OFF |=> !evt_out.status && !evt_out.warn && !evt_out.trip)
		else $error("disabled instance shows a condition");

	no_action_a: assert property (
		clk_en && st_q.cfg.action == ACT_NONE |=> !evt_out.warn && !evt_out.trip)
		else $error("no-action setting produced an event");

	warn_follow_a: assert property (
		clk_en && st_q.cfg.action == ACT_WARN
		|=> evt_out.warn == evt_out.status && (!evt_out.warn || evt_out.warn_code == CODE_WARN))
		else $error("warning does not track the condition");

	fault_trip_a: assert property (
		clk_en && st_q.cfg.action == ACT_FAULT
		|=> evt_out.trip == evt_out.status && (!evt_out.trip || evt_out.trip_code == CODE_FAULT))
		else $error("fault trip does not track the condition");

	run_trip_a: assert property (
		clk_en && st_q.cfg.action == ACT_FAULT_RUN
		|=> evt_out.trip == (evt_out.status && $past(motor_run)) && !evt_out.warn)
		else $error("running trip ignores motor state");

	filt_pass_a: assert property (
		s_step_on ##0 st_q.cfg.filt_ms == 16'h0000 |=> filt_out == $past(sig_sel))
		else $error("zero filter time does not pass the signal");

	cfg_range_a: assert property (
		st_q.cfg.filt_ms <= FILT_MAX_MS && st_q.cfg.hyst <= HYST_MAX
		&& st_q.cfg.low <= LIMIT_MAX && st_q.cfg.low >= -LIMIT_MAX
		&& st_q.cfg.high <= LIMIT_MAX && st_q.cfg.high >= -LIMIT_MAX)
		else $error("configuration outside its legal range");

	low_set_a: assert property (
		s_step_on ##0 st_q.cfg.mode == MODE_LOW && below_lo |=> evt_out.status)
		else $error("low mode missed a crossing below the threshold");

	high_clear_a: assert property (
		s_step_on ##0 st_q.cfg.mode == MODE_HIGH && below_hi |=> !evt_out.status)
		else $error("high mode did not clear below the threshold");

	hyst_hold_a: assert property (
		s_step_on ##0 st_q.cfg.mode == MODE_HYST && !above_hi && !below_lo
		|=> evt_out.status == $past(evt_out.status))
		else $error("hysteresis mode changed state inside the band");

	fall_set_a: assert property (
		s_lo_armed_drop |=> evt_out.status)
		else $error("falling mode missed an armed fall");

	fall_idle_a: assert property (
		s_lo_idle_drop |=> !evt_out.status)
		else $error("falling mode set without a prior high value");

	freeze_a: assert property (
		!clk_en |=> $stable(st_q))
		else $error("state moved while enable was low");

endmodule
`default_nettype wire

// ---- verification/test_sls_supervisor.sv ----
// Purpose: Self-checking bench for one signal limit supervision instance
// Assumes: Outputs settle within two cycles of a tick; clk_en high except in the freeze test
// Notes:   Half hysteresis of 10 keeps every threshold in the mode table exact
`timescale 1ns/1ps
`default_nettype none
module test_sls_supervisor
	import sls_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int unsigned TICK = 1;
	logic                    clk;
	logic                    reset_n;
	logic                    clk_en;
	logic                    tick;
	logic                    cfg_wr;
	logic                    motor_run;
	sls_cfg_t                cfg_in;
	logic signed [7:0][31:0] sig_vec;
	sls_cfg_t                cfg_out;
	logic signed [31:0]      filt_out;
	sls_evt_t                evt_out;
	int                      err_total;
	int                      compares;
	int                      cur_sel;

	sls_supervisor #(
		.NSIG    (8),
		.TICK_MS (TICK)
	) u_dut (
		.clk       (clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.tick      (tick),
		.cfg_wr    (cfg_wr),
		.cfg_in    (cfg_in),
		.sig_vec   (sig_vec),
		.motor_run (motor_run),
		.cfg_out   (cfg_out),
		.filt_out  (filt_out),
		.evt_out   (evt_out)
	);

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Compare and drive helpers
	// ----------------------------------------------------------------
	task automatic chk1(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Inputs move 1 ns after the edge so the design never races the bench
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Trailing idle cycle keeps two writes from toggling cfg_wr in one step
	task automatic wr_cfg(input logic [3:0] m, input logic [1:0] a, input logic [3:0] s, input logic [15:0] f,
		input logic signed [31:0] lo, input logic signed [31:0] hi, input logic [31:0] h);
		cfg_in = '{mode: m, action: a, sel: s, filt_ms: f, low: lo, high: hi, hyst: h};
		cur_sel = int'(s);
		cfg_wr = 1'b1;
		cyc(1);
		cfg_wr = 1'b0;
		cyc(1);
	endtask

	// Unselected inputs carry a decoy so a wrong selection shows up
	task automatic step(input logic signed [31:0] v);
		for (int i = 0; i < 8; i++) begin
			sig_vec[i] = (i == cur_sel) ? v : 32'sh0001_E240;
		end
		tick = 1'b1;
		cyc(1);
		tick = 1'b0;
		cyc(1);
	endtask

	task automatic chk_evt(input logic st, input logic [1:0] a);
		logic w;
		logic t;
		w = st && (a == ACT_WARN);
		t = st && ((a == ACT_FAULT) || ((a == ACT_FAULT_RUN) && motor_run));
		chk1(evt_out.status, st, "status");
		chk1(evt_out.warn, w, "warn flag");
		chk1(evt_out.trip, t, "trip flag");
		chk16(evt_out.warn_code, w ? CODE_WARN : CODE_NONE, "warn code");
		chk16(evt_out.trip_code, !t ? CODE_NONE : ((a == ACT_FAULT_RUN) ? CODE_FLT_RUN : CODE_FAULT),
			"trip code");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		chk32(32'(cfg_out.mode), 32'(MODE_OFF), "reset mode");
		chk32(32'(cfg_out.action), 32'(ACT_NONE), "reset action");
		chk32(32'(cfg_out.sel), 32'(SEL_TORQUE), "reset select");
		chk32(32'(cfg_out.filt_ms), 32'h0000_0000, "reset filter");
		chk32(cfg_out.low, 32'h0000_0000, "reset low");
		chk32(cfg_out.high, 32'h0000_0000, "reset high");
		chk32(cfg_out.hyst, 32'h0000_0000, "reset hyst");
		// Default mode must stay silent even far below the zero limits
		step(-32'sh0000_01F4);
		chk32(filt_out, -32'sh0000_01F4, "torque passthrough");
		chk_evt(1'b0, ACT_NONE);
		$display("test_reset done");
	endtask

	// Modes 1 to 7 walk set, hold inside the hysteresis and clear; edge modes arm, set and rearm; off stays quiet
	task automatic test_modes();
		int         lo [10] = '{-100, -100, 0, 100, 0, -100, 50, -100, -100, 0};
		int         hi [10] = '{100, 0, 100, 0, 100, 100, 100, 100, 0, 100};
		int         sg [10][4] = '{'{-200, 200, -200, 0}, '{-105, -111, -95, -89}, '{105, 111, 95, 89},
			'{-95, -85, 105, -115}, '{-105, -115, 95, -85}, '{0, -111, -95, 85}, '{-75, -115, -95, -75},
			'{0, 111, 0, -111}, '{-111, -85, -111, -85}, '{111, 85, 111, 85}};
		logic [3:0] ex [10] = '{4'h0, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h4, 4'h4};
		for (int m = 0; m < 10; m++) begin
			wr_cfg(4'(m), ACT_FAULT, SEL_TORQUE, 16'h0000, lo[m], hi[m], 32'h0000_0014);
			for (int j = 0; j < 4; j++) begin
				step(sg[m][j]);
				chk32(filt_out, sg[m][j], "unfiltered value");
				chk_evt(ex[m][j], ACT_FAULT);
			end
		end
		$display("test_modes done");
	endtask

	// Status is the same for every action; only warn and trip differ
	task automatic test_actions();
		for (int a = 0; a < 4; a++) begin
			wr_cfg(MODE_LOW, 2'(a), SEL_TORQUE, 16'h0000, 32'sh0, 32'sh0, 32'h0);
			step(32'sh0000_000A);
			chk_evt(1'b0, 2'(a));
			step(-32'sh0000_000A);
			chk_evt(1'b1, 2'(a));
			motor_run = 1'b1;
			cyc(2);
			chk_evt(1'b1, 2'(a));
			motor_run = 1'b0;
			cyc(2);
			chk_evt(1'b1, 2'(a));
		end
		$display("test_actions done");
	endtask

	// Filter step response on a non-default input, then range clamping
	task automatic test_filter();
		int e;
		int k;
		e = 0;
		k = 3 / int'(TICK) + 1;
		wr_cfg(MODE_OFF, ACT_NONE, 4'h2, 16'h0000, 32'sh0, 32'sh0, 32'h0);
		step(32'sh0);
		chk32(filt_out, 32'h0000_0000, "filter settle");
		wr_cfg(MODE_OFF, ACT_NONE, 4'h2, 16'h0003, 32'sh0, 32'sh0, 32'h0);
		for (int i = 0; i < 3; i++) begin
			e = e + (400 - e) / k;
			step(32'sh0000_0190);
			chk32(filt_out, e, "filter step");
		end
		wr_cfg(MODE_OFF, ACT_NONE, SEL_TORQUE, 16'hFFFF, 32'sh8000_0000, 32'sh7FFF_FFFF, 32'hFFFF_FFFF);
		chk32(32'(cfg_out.filt_ms), 32'h0000_7530, "filter clamp");
		chk32(cfg_out.low, -32'sh7FFF_FFD0, "low clamp");
		chk32(cfg_out.high, 32'sh7FFF_FFD0, "high clamp");
		chk32(cfg_out.hyst, 32'h0098_9680, "hyst clamp");
		$display("test_filter done");
	endtask

	// Enable low must hold filter, condition and configuration; then an unused select reads zero
	task automatic test_freeze();
		wr_cfg(MODE_LOW, ACT_WARN, SEL_TORQUE, 16'h0000, 32'sh0, 32'sh0, 32'h0);
		step(32'sh0000_000A);
		chk_evt(1'b0, ACT_WARN);
		sig_vec[0] = -32'sh0000_000A;
		cfg_in.mode = MODE_HIGH;
		clk_en = 1'b0;
		tick = 1'b1;
		cfg_wr = 1'b1;
		cyc(2);
		chk32(filt_out, 32'h0000_000A, "frozen filter");
		chk32(32'(cfg_out.mode), 32'(MODE_LOW), "frozen mode");
		chk_evt(1'b0, ACT_WARN);
		cfg_wr = 1'b0;
		tick = 1'b0;
		clk_en = 1'b1;
		step(-32'sh0000_000A);
		chk_evt(1'b1, ACT_WARN);
		wr_cfg(MODE_OFF, ACT_NONE, 4'hF, 16'h0000, 32'sh0, 32'sh0, 32'h0);
		step(32'sh0000_01F4);
		chk32(filt_out, 32'h0000_0000, "unused select");
		$display("test_freeze done");
	endtask

	// ----------------------------------------------------------------
	// Verdict and sequence
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("Counts: %0d compares, %0d mismatches", compares, err_total);
		if ((err_total == 0) && (compares > 0)) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Guards against a hang anywhere in the sequence
	initial begin
		#200us;
		err_total++;
		$display("FAIL %0t run limit reached", $time);
		finish_test();
	end

	initial begin
		err_total = 0;
		compares = 0;
		cur_sel = 0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		tick = 1'b0;
		cfg_wr = 1'b0;
		motor_run = 1'b0;
		cfg_in = CFG_RST;
		sig_vec = '0;
		cyc(20);
		reset_n = 1'b1;
		cyc(1);
		test_reset();
		test_modes();
		test_actions();
		test_filter();
		test_freeze();
		finish_test();
	end
endmodule
`default_nettype wire
